// ===== hw/dsbsp_pkg.sv
// Notes on behaviour
// - Read latency 1.5 cycles, 1 with loop off
// - Controls sampled at positive input clock rise
// - Write data taken on both input clocks
// - Read data launched from output registers
// - Read: select high, strobe low, address stored
// - Burst of two 18-bit words per address
// - Low word first, second word next edge
// - New read every positive edge, pipelined
// - Deselected reads finish, then outputs float
// - Write: select low, strobe low, address stored
// - Two write words, combined 36 bits stored
// - New write every positive edge accepted
// - Deselected writes finish, inputs then ignored
// - Byte selects sampled with each word
// - Single clock strap caught once after each reset
// - Write held in registers, committed later
// - Deselected with outputs floating after reset
// - Loop lock needs 1024 stable clock cycles
// - Loop disable input is active low
package dsbsp_pkg;

  localparam int ADDR_W = 19;
  localparam int WORD_W = 18;
  localparam int LANE_W = 9;
  localparam int LANES = 4;
  localparam int DEPTH = 524288;
  localparam int APB_AW = 12;

  typedef logic [ADDR_W-1:0] dsbsp_addr_t;
  typedef logic [WORD_W-1:0] dsbsp_word_t;
  typedef logic [2*WORD_W-1:0] dsbsp_pair_t;
  typedef logic [LANES-1:0] dsbsp_lane_t;

  // Register byte addresses
  localparam logic [APB_AW-1:0] REG_CTRL = 12'h000;
  localparam logic [APB_AW-1:0] REG_STATUS = 12'h004;
  localparam logic [APB_AW-1:0] REG_LOCK_COUNT = 12'h008;

  // Control fields and reset value
  localparam int CTRL_ENABLE_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

  // Status fields
  localparam int STAT_SINGLE_CLK_BIT = 0;
  localparam int STAT_LOCKED_BIT = 1;
  localparam int STAT_OUT_ACTIVE_BIT = 2;
  localparam int STAT_POSTED_BIT = 3;
  localparam int STAT_LOOP_ON_BIT = 4;

  // Loop lock time in positive input clock cycles
  localparam int LOCK_CYCLES = 1024;
  localparam int LOCK_W = 11;
  localparam logic [LOCK_W-1:0] LOCK_DONE = LOCK_W'(LOCK_CYCLES);

  // Pipeline depth in half cycles of the input clock
  localparam int PIPE_W = 4;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [APB_AW-1:0] paddr;
    logic [31:0] pwdata;
  } dsbsp_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } dsbsp_apb_rsp_s;

endpackage

// ===== hw/dsbsp_array.sv
`timescale 1ns/100ps
module dsbsp_array (
  input wire logic sys_clk,
  input wire dsbsp_pkg::dsbsp_addr_t wrAddr,
  input wire dsbsp_pkg::dsbsp_lane_t wrLane,
  input wire dsbsp_pkg::dsbsp_pair_t wrData,
  input wire logic rdEn,
  input wire dsbsp_pkg::dsbsp_addr_t rdAddr,
  output dsbsp_pkg::dsbsp_pair_t rdData
);
  import dsbsp_pkg::*;

  dsbsp_pair_t mem [0:DEPTH-1];

  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < LANES; i++) begin
      if (wrLane[i]) begin
        mem[wrAddr][i*LANE_W +: LANE_W] <= wrData[i*LANE_W +: LANE_W];
      end
    end
  end

  // A lane written in the same cycle is passed through, so a commit is never missed
  always_ff @(posedge sys_clk) begin
    if (rdEn) begin
      for (int i = 0; i < LANES; i++) begin
        if (wrLane[i] && (wrAddr == rdAddr)) begin
          rdData[i*LANE_W +: LANE_W] <= wrData[i*LANE_W +: LANE_W];
        end else begin
          rdData[i*LANE_W +: LANE_W] <= mem[rdAddr][i*LANE_W +: LANE_W];
        end
      end
    end
  end

endmodule // dsbsp_array

// ===== hw/dsbsp_port.sv
`timescale 1ns/100ps
module dsbsp_port (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire dsbsp_pkg::dsbsp_apb_req_s apbReq,
  output dsbsp_pkg::dsbsp_apb_rsp_s apbRsp,
  input wire logic loadStrobeN,
  input wire logic readNotWrite,
  input wire dsbsp_pkg::dsbsp_addr_t addr,
  input wire logic [1:0] byteWriteSelectN,
  input wire dsbsp_pkg::dsbsp_word_t dataIn,
  input wire logic loopDisableN,
  input wire logic outClkP,
  input wire logic outClkN,
  output dsbsp_pkg::dsbsp_word_t dataOut,
  output logic dataOutEn,
  output logic echoClock
);
  import dsbsp_pkg::*;

  function automatic dsbsp_pair_t mergeLanes(dsbsp_pair_t base, dsbsp_pair_t upd, dsbsp_lane_t lanes);
    dsbsp_pair_t res;
    res = base;
    for (int i = 0; i < LANES; i++) begin
      if (lanes[i]) begin
        res[i*LANE_W +: LANE_W] = upd[i*LANE_W +: LANE_W];
      end
    end
    return res;
  endfunction

  // Each sys_clk edge is one half of the input clock: even edges are the positive rise
  logic phase_q;
  logic kRise;
  logic ctrlEnable_q;
  logic cmdValid;
  logic rdCmd;
  logic wrCmd;
  logic [PIPE_W-1:0] rdPipe_q;
  logic [PIPE_W-1:0] wrPipe_q;
  dsbsp_addr_t rdAddr_q;
  dsbsp_addr_t wrAddr_q;
  dsbsp_addr_t stgAddr_q;
  dsbsp_pair_t stgData_q;
  dsbsp_lane_t stgLane_q;
  logic stgValid_q;
  dsbsp_addr_t pendAddr_q;
  dsbsp_pair_t pendData_q;
  dsbsp_lane_t pendLane_q;
  logic pendValid_q;
  dsbsp_lane_t commitLane;
  dsbsp_pair_t memRdData;
  dsbsp_pair_t merged;
  dsbsp_word_t hold0_q;
  dsbsp_word_t hold1_q;
  logic launch0;
  logic launch1;
  dsbsp_word_t dataOut_q;
  logic dataOutEn_q;
  logic echo_q;
  logic [LOCK_W-1:0] lockCnt_q;
  logic strapDone_q;
  logic singleClk_q;
  logic [31:0] prdata_q;
  logic regHit;
  logic [31:0] regRead;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase_q <= 1'b0;
    end else begin
      phase_q <= ~phase_q;
    end
  end

  assign kRise = ~phase_q;

  assign cmdValid = kRise && !loadStrobeN && ctrlEnable_q;

  assign rdCmd = cmdValid && readNotWrite;

  assign wrCmd = cmdValid && !readNotWrite;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdPipe_q <= '0;
      wrPipe_q <= '0;
    end else begin
      rdPipe_q <= {rdPipe_q[PIPE_W-2:0], rdCmd};
      wrPipe_q <= {wrPipe_q[PIPE_W-2:0], wrCmd};
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdAddr_q <= '0;
      wrAddr_q <= '0;
    end else begin
      if (rdCmd) begin
        rdAddr_q <= addr;
      end
      if (wrCmd) begin
        wrAddr_q <= addr;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stgAddr_q <= '0;
      stgData_q <= '0;
      stgLane_q <= '0;
    end else begin
      if (wrPipe_q[1]) begin
        stgAddr_q <= wrAddr_q;
        stgData_q[WORD_W-1:0] <= dataIn;
        stgLane_q[1:0] <= ~byteWriteSelectN;
      end
      if (wrPipe_q[2]) begin
        stgData_q[2*WORD_W-1:WORD_W] <= dataIn;
        stgLane_q[3:2] <= ~byteWriteSelectN;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stgValid_q <= 1'b0;
    end else if (wrPipe_q[1]) begin
      stgValid_q <= 1'b1;
    end else if (wrPipe_q[3]) begin
      stgValid_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pendAddr_q <= '0;
      pendData_q <= '0;
      pendLane_q <= '0;
      pendValid_q <= 1'b0;
    end else if (wrPipe_q[3]) begin
      pendAddr_q <= stgAddr_q;
      pendData_q <= stgData_q;
      pendLane_q <= stgLane_q;
      pendValid_q <= 1'b1;
    end
  end

  assign commitLane = (wrPipe_q[3] && pendValid_q) ? pendLane_q : '0;

  // one array holding each 36-bit word
  dsbsp_array u_array (
    .sys_clk(sys_clk),
    .wrAddr(pendAddr_q),
    .wrLane(commitLane),
    .wrData(pendData_q),
    .rdEn(rdCmd),
    .rdAddr(addr),
    .rdData(memRdData)
  );

  always_comb begin
    merged = memRdData;
    if (pendValid_q && (pendAddr_q == rdAddr_q)) begin
      merged = mergeLanes(merged, pendData_q, pendLane_q);
    end
    if (stgValid_q && (stgAddr_q == rdAddr_q)) begin
      merged = mergeLanes(merged, stgData_q, stgLane_q);
    end
  end

  // Word 1 merge waits a half cycle so a write just ahead has its second word in
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hold0_q <= '0;
      hold1_q <= '0;
    end else begin
      if (rdPipe_q[0]) begin
        hold0_q <= merged[WORD_W-1:0];
      end
      if (rdPipe_q[1]) begin
        hold1_q <= merged[2*WORD_W-1:WORD_W];
      end
    end
  end

  assign launch0 = loopDisableN ? rdPipe_q[2] : rdPipe_q[1];
  assign launch1 = loopDisableN ? rdPipe_q[3] : rdPipe_q[2];

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dataOut_q <= '0;
    end else if (launch0) begin
      dataOut_q <= hold0_q;
    end else if (launch1) begin
      dataOut_q <= hold1_q;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      dataOutEn_q <= 1'b0;
    end else if (launch0 || launch1) begin
      dataOutEn_q <= 1'b1;
    end else if (kRise) begin
      dataOutEn_q <= 1'b0;
    end
  end

  // Echo runs free, high for the half after each positive rise
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      echo_q <= 1'b0;
    end else begin
      echo_q <= kRise;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lockCnt_q <= '0;
    end else if (!loopDisableN) begin
      lockCnt_q <= '0;
    end else if (kRise && (lockCnt_q != LOCK_DONE)) begin
      lockCnt_q <= lockCnt_q + LOCK_W'(1);
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      strapDone_q <= 1'b0;
      singleClk_q <= 1'b0;
    end else if (!strapDone_q) begin
      strapDone_q <= 1'b1;
      singleClk_q <= outClkP && outClkN;
    end
  end

  // Single clock mode only shows in status: output timing is zero skew either way
  always_comb begin
    regHit = 1'b1;
    regRead = '0;
    if (apbReq.paddr == REG_CTRL) begin
      regRead[CTRL_ENABLE_BIT] = ctrlEnable_q;
    end else if (apbReq.paddr == REG_STATUS) begin
      regRead[STAT_SINGLE_CLK_BIT] = singleClk_q;
      regRead[STAT_LOCKED_BIT] = (lockCnt_q == LOCK_DONE);
      regRead[STAT_OUT_ACTIVE_BIT] = dataOutEn_q;
      regRead[STAT_POSTED_BIT] = pendValid_q;
      regRead[STAT_LOOP_ON_BIT] = loopDisableN;
    end else if (apbReq.paddr == REG_LOCK_COUNT) begin
      regRead[LOCK_W-1:0] = lockCnt_q;
    end else begin
      regHit = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata_q <= '0;
    end else if (apbReq.psel && !apbReq.penable) begin
      prdata_q <= regRead;
    end
  end

  // Disabling stops new commands only; bursts in flight still finish
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrlEnable_q <= CTRL_RESET[CTRL_ENABLE_BIT];
    end else if (apbReq.psel && apbReq.penable && apbReq.pwrite && (apbReq.paddr == REG_CTRL)) begin
      ctrlEnable_q <= apbReq.pwdata[CTRL_ENABLE_BIT];
    end
  end

  assign apbRsp.prdata = prdata_q;
  assign apbRsp.pready = 1'b1;
  assign apbRsp.pslverr = apbReq.psel && apbReq.penable && !regHit;

  assign dataOut = dataOut_q;
  assign dataOutEn = dataOutEn_q;
  assign echoClock = echo_q;

endmodule // dsbsp_port

// ===== tb/dsbsp_port_props.sv
`timescale 1ns/100ps
module dsbsp_port_chk (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire dsbsp_pkg::dsbsp_apb_req_s apbReq,
  input wire dsbsp_pkg::dsbsp_apb_rsp_s apbRsp,
  input wire logic loadStrobeN,
  input wire logic readNotWrite,
  input wire logic loopDisableN,
  input wire dsbsp_pkg::dsbsp_word_t dataOut,
  input wire logic dataOutEn,
  input wire logic echoClock
);
  import dsbsp_pkg::*;
  logic phQ;
  logic enQ;
  logic [3:0] idleQ;
  logic rdGo;
  assign rdGo = !phQ && !loadStrobeN && readNotWrite && enQ;
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) phQ <= 1'b0;
    else phQ <= ~phQ;
  end
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) enQ <= 1'b1;
    else if (apbReq.psel && apbReq.penable && apbReq.pwrite && apbRsp.pready && apbReq.paddr == REG_CTRL)
      enQ <= apbReq.pwdata[CTRL_ENABLE_BIT];
  end
  // Saturates, so reset also counts as a long idle spell
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) idleQ <= 4'hF;
    else if (rdGo) idleQ <= 4'h0;
    else if (idleQ != 4'hF) idleQ <= idleQ + 4'h1;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  sequence s_two;
    dataOutEn [*2];
  endsequence
  sequence s_four;
    dataOutEn [*4];
  endsequence
  property p_lat_on;
    rdGo && loopDisableN |-> ##4 s_two;
  endproperty
  a_lat_on: assert property (p_lat_on) else $error("read burst late, loop on");
  property p_lat_off;
    rdGo && !loopDisableN |-> ##3 s_two;
  endproperty
  a_lat_off: assert property (p_lat_off) else $error("read burst late, loop off");
  property p_pipe;
    rdGo && loopDisableN ##2 rdGo |-> ##2 s_four;
  endproperty
  a_pipe: assert property (p_pipe) else $error("gap between pipelined bursts");
  property p_float;
    idleQ >= 4'h6 |-> !dataOutEn;
  endproperty
  a_float: assert property (p_float) else $error("outputs driven while idle");
  property p_hold;
    !dataOutEn && !$past(dataOutEn) |-> $stable(dataOut);
  endproperty
  a_hold: assert property (p_hold) else $error("data changed while floating");
  property p_echo;
    echoClock == phQ;
  endproperty
  a_echo: assert property (p_echo) else $error("echo clock out of phase");
  property p_ready;
    apbReq.psel && apbReq.penable |-> apbRsp.pready;
  endproperty
  a_ready: assert property (p_ready) else $error("bus access not answered");
  property p_err;
    apbReq.psel && apbReq.penable |-> apbRsp.pslverr ==
      !(apbReq.paddr == REG_CTRL || apbReq.paddr == REG_STATUS || apbReq.paddr == REG_LOCK_COUNT);
  endproperty
  a_err: assert property (p_err) else $error("bus error flag wrong");
endmodule // dsbsp_port_chk

bind dsbsp_port dsbsp_port_chk chk_u (.sys_clk, .sys_rst, .apbReq, .apbRsp, .loadStrobeN, .readNotWrite,
  .loopDisableN, .dataOut, .dataOutEn, .echoClock);

// ===== tb/dsbsp_host.sv
`timescale 1ns/100ps
module dsbsp_host (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic loopDisableN,
  input wire dsbsp_pkg::dsbsp_word_t dataOut,
  output logic loadStrobeN,
  output logic readNotWrite,
  output dsbsp_pkg::dsbsp_addr_t addr,
  output logic [1:0] byteWriteSelectN,
  output dsbsp_pkg::dsbsp_word_t dataIn
);
  import dsbsp_pkg::*;
  int edgeQ;
  int nx;
  logic [59:0] cmdQ[$];
  dsbsp_word_t got[$];
  dsbsp_word_t dSlot[int];
  logic [1:0] bSlot[int];
  bit capSlot[int];
  initial begin
    loadStrobeN = 1'b1;
    readNotWrite = 1'b0;
    addr = '0;
    dataIn = '0;
    byteWriteSelectN = 2'h3;
  end
  always @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) edgeQ <= -1;
    else edgeQ <= edgeQ + 1;
  end
  always @(posedge sys_clk) begin
    logic [59:0] c;
    nx = sys_rst ? 0 : edgeQ + 2;
    if (capSlot.exists(nx - 1)) got.push_back(dataOut);
    if (nx[0] == 1'b0 && cmdQ.size() > 0) begin
      c = cmdQ.pop_front();
      loadStrobeN <= 1'b0;
      readNotWrite <= c[59];
      addr <= c[58:40];
      if (c[59]) begin
        capSlot[nx + (loopDisableN ? 4 : 3)] = 1'b1;
        capSlot[nx + (loopDisableN ? 5 : 4)] = 1'b1;
      end else begin
        // words and selects two and three edges later
        dSlot[nx + 2] = c[17:0];
        dSlot[nx + 3] = c[35:18];
        bSlot[nx + 2] = c[37:36];
        bSlot[nx + 3] = c[39:38];
      end
    end else begin
      loadStrobeN <= 1'b1;
      readNotWrite <= ~readNotWrite;
      addr <= ~addr;
    end
    // Lines outside a data slot toggle so stale values cannot pass
    if (dSlot.exists(nx)) begin
      dataIn <= dSlot[nx];
      byteWriteSelectN <= bSlot[nx];
    end else begin
      dataIn <= ~dataIn;
      byteWriteSelectN <= ~byteWriteSelectN;
    end
  end
endmodule // dsbsp_host

// ===== tb/ddr_sio_burst2_sram_port_test.sv
`timescale 1ns/100ps
`define CMP(g, e) begin checked++; if ((g) !== (e)) begin n_errors++; $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module ddr_sio_burst2_sram_port_test;
  import dsbsp_pkg::*;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic loopDisableN = 1'b1;
  logic strapHigh = 1'b1;
  dsbsp_apb_req_s apbReq = '0;
  dsbsp_apb_rsp_s apbRsp;
  logic loadStrobeN;
  logic readNotWrite;
  dsbsp_addr_t addr;
  logic [1:0] byteWriteSelectN;
  dsbsp_word_t dataIn;
  dsbsp_word_t dataOut;
  int n_errors = 0;
  int checked = 0;
  logic [35:0] mem[int];
  dsbsp_word_t exp[$];
  always #50 sys_clk = ~sys_clk;
  // output clocks strapped high or not
  dsbsp_port dut_u (.sys_clk, .sys_rst, .apbReq, .apbRsp, .loadStrobeN, .readNotWrite, .addr, .byteWriteSelectN,
    .dataIn, .loopDisableN, .outClkP(strapHigh), .outClkN(strapHigh), .dataOut, .dataOutEn(), .echoClock());
  dsbsp_host host_u (.sys_clk, .sys_rst, .loopDisableN, .dataOut, .loadStrobeN, .readNotWrite, .addr,
    .byteWriteSelectN, .dataIn);
  task automatic print_verdict();
    if (n_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(input logic [18:0] a, input logic [35:0] d, input logic [3:0] bw);
    logic [35:0] m;
    m = mem.exists(a) ? mem[a] : '0;
    for (int l = 0; l < 4; l++) if (!bw[l]) m[l*9 +: 9] = d[l*9 +: 9];
    mem[a] = m;
    host_u.cmdQ.push_back({1'b0, a, bw, d});
  endtask
  task automatic rd(input logic [18:0] a);
    host_u.cmdQ.push_back({1'b1, a, 4'hF, 36'h0});
    exp.push_back(mem[a][17:0]);
    exp.push_back(mem[a][35:18]);
  endtask
  task automatic drain();
    int k;
    dsbsp_word_t gw;
    dsbsp_word_t ew;
    k = 0;
    while (host_u.cmdQ.size() != 0 && k < 500) begin @(posedge sys_clk); k++; end
    if (k >= 500) begin n_errors++; print_verdict(); end
    repeat (12) @(posedge sys_clk);
    `CMP(host_u.got.size(), exp.size())
    // Popped once each, as the compare macro reads its arguments twice
    while (exp.size() > 0 && host_u.got.size() > 0) begin
      gw = host_u.got.pop_front();
      ew = exp.pop_front();
      `CMP(gw, ew)
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
    int k;
    k = 0;
    apbReq <= {1'b1, 1'b0, w, a, d};
    @(posedge sys_clk);
    apbReq.penable <= 1'b1;
    do begin @(posedge sys_clk); k++; end while (apbRsp.pready !== 1'b1 && k < 50);
    r = apbRsp.prdata;
    e = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
    if (k >= 50) begin n_errors++; print_verdict(); end
    // An idle edge, so a following call never reassigns psel in this step
    @(posedge sys_clk);
  endtask
  initial begin
    logic [31:0] r;
    logic e;
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    // stable clock before relying on the loop
    repeat (2100) @(posedge sys_clk);
    apb(1'b0, REG_CTRL, 32'h0, r, e);
    `CMP(r, CTRL_RESET)
    apb(1'b0, REG_STATUS, 32'h0, r, e);
    `CMP(r[4:0], 5'h13)
    wr(19'h1, 36'h1_2345_6789, 4'h0);
    wr(19'h2, 36'hA_BCDE_F012, 4'h0);
    rd(19'h1);
    rd(19'h2);
    rd(19'h1);
    wr(19'h1, 36'h5_A5A5_A5A5, 4'h0);
    rd(19'h1);
    drain();
    for (int i = 0; i < 16; i++) begin
      wr(19'h3, {4{9'(i * 37 + 5)}}, 4'(i));
      rd(19'h3);
    end
    drain();
    loopDisableN <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rd(19'h1);
    rd(19'h3);
    rd(19'h2);
    drain();
    loopDisableN <= 1'b1;
    apb(1'b1, REG_CTRL, 32'h0, r, e);
    apb(1'b0, REG_CTRL, 32'h0, r, e);
    `CMP(r[0], 1'b0)
    host_u.cmdQ.push_back({1'b0, 19'h1, 4'h0, 36'h0});
    drain();
    apb(1'b1, REG_CTRL, 32'h1, r, e);
    rd(19'h1);
    drain();
    apb(1'b0, 12'hFFC, 32'h0, r, e);
    `CMP({e, r}, {1'b1, 32'h0})
    // a fresh reset catches the strap low
    strapHigh <= 1'b0;
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    apb(1'b0, REG_STATUS, 32'h0, r, e);
    `CMP(r[4:0], 5'h10)
    print_verdict();
  end
endmodule // ddr_sio_burst2_sram_port_test
